/* testbench/ibc_loop_code_rx_tb.sv */
// self-checking bench for the receive in-band loop code block
`timescale 1ns/1ns
module ibc_loop_code_rx_tb;
  import ibc_pkg::*;
  localparam int IC    = 200;    // short window keeps the run small
  localparam int LIMIT = 20_000; // whole run is about 2,100 cycles
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_bit_en;
  logic        rx_data;
  logic        up_det;
  logic        dn_det;
  logic        irq;
  logic        s_on;
  logic [15:0] s_pat;
  int          s_len;
  int          s_err;
  int          s_idx;
  int          s_cnt;
  int          fails;
  int          check_count;
  int          cycles;
  logic [7:0]  regs [7] = '{IDX_CONTROL, IDX_UP_LOW, IDX_UP_HIGH, IDX_DOWN_LOW, IDX_DOWN_HIGH, IDX_STATUS, IDX_MASK};

  ibc_loop_code_rx #(.INTEG_CYCLES(IC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_bit_en(rx_bit_en), .rx_data(rx_data), .up_code_detected(up_det),
    .down_code_detected(dn_det), .irq(irq)
  );

  // clock of 20 ns
  always #10 hclk = ~hclk;

  // repeating line stream, first bit at s_pat[15]; idle line toggles so no stale level is seen
  always @(posedge hclk) begin
    rx_bit_en <= s_on;
    rx_data   <= s_on ? (s_pat[15 - s_idx] ^ (s_err != 0 && s_cnt % s_err == 0)) : ~rx_data;
    s_idx     <= (s_idx + 1 >= s_len) ? 0 : s_idx + 1;
    s_cnt     <= s_cnt + 1;
  end

  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single AHB-Lite transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ad

  task automatic wr(input logic [31:0] addr, input logic [31:0] d);
    logic [31:0] v;
    bus(addr, 1'b1, d, v);
  endtask : wr

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    bus(addr, 1'b0, 32'h0000_0000, v);
    check(v, exp);
  endtask : rd_chk

  // change the line stream, then give the detector two whole windows plus its pipeline
  task automatic stream(input logic on, input logic [15:0] p, input int len, input int err);
    @(posedge hclk);
    s_on  <= on;
    s_pat <= p;
    s_len <= len;
    s_err <= err;
    repeat (2 * IC + 4) @(posedge hclk);
    #1;
  endtask : stream

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    rx_bit_en = 0; rx_data = 0; s_on = 0; s_pat = 0; s_len = 16; s_err = 0; s_idx = 0; s_cnt = 0;
    fails = 0; check_count = 0; cycles = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    foreach (regs[i]) rd_chk(ad(regs[i]), 32'h0000_0000);
    check(hresp, 0);
    check(hreadyout, 1);
    // unmapped places read zero and ignore writes
    wr(ad(8'h0b), 32'h0000_00ff);
    rd_chk(ad(8'h0b), 32'h0000_0000);
    rd_chk(32'h0000_0400, 32'h0000_0000);
    wr(ad(IDX_UP_HIGH), 32'hffff_ffa5);
    wr(ad(IDX_UP_LOW), 32'h0000_00c3);
    wr(ad(IDX_DOWN_LOW), 32'h0000_005a);
    rd_chk(ad(IDX_UP_HIGH), 32'h0000_00a5);
    rd_chk(ad(IDX_UP_LOW), 32'h0000_00c3);
    rd_chk(ad(IDX_DOWN_LOW), 32'h0000_005a);
    // 16-bit loop-up code, down length 1 of zero must not match
    wr(ad(IDX_MASK), 32'h0000_0002);
    wr(ad(IDX_CONTROL), 32'h0000_0038);
    stream(1'b1, 16'ha5c3, 16, 0);
    check(up_det, 1);
    check(dn_det, 0);
    check(irq, 1);
    rd_chk(ad(IDX_STATUS), 32'h0000_0002);
    wr(ad(IDX_MASK), 32'h0000_0000);
    rd_chk(ad(IDX_MASK), 32'h0000_0000);
    check(irq, 0);
    // silent line drops the verdict, status clears by writing ones
    stream(1'b0, 16'h0000, 16, 0);
    check(up_det, 0);
    wr(ad(IDX_STATUS), 32'h0000_0003);
    rd_chk(ad(IDX_STATUS), 32'h0000_0000);
    // short codes with garbage in the ignored low bits
    wr(ad(IDX_CONTROL), 32'h0000_0013);
    wr(ad(IDX_UP_LOW), 32'h0000_00b7);
    wr(ad(IDX_DOWN_LOW), 32'h0000_009a);
    wr(ad(IDX_MASK), 32'h0000_0003);
    stream(1'b1, 16'ha000, 3, 0);
    check(up_det, 1);
    check(dn_det, 0);
    stream(1'b1, 16'h9000, 4, 0);
    check(dn_det, 1);
    check(up_det, 0);
    rd_chk(ad(IDX_STATUS), 32'h0000_0003);
    check(irq, 1);
    // one bit in a hundred flipped still counts as the code
    wr(ad(IDX_CONTROL), 32'h0000_0038);
    wr(ad(IDX_UP_LOW), 32'h0000_00c3);
    stream(1'b1, 16'ha5c3, 16, 100);
    check(up_det, 1);
    check(dn_det, 0);
    end_of_test();
  end
endmodule : ibc_loop_code_rx_tb

/* verilog/ibc_code_det.sv */
// one repeating-pattern detector with error-tolerant integration
`timescale 1ns/1ns
module ibc_code_det (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 bit_en,
  input  wire logic [15:0]          window,
  input  ibc_pkg::ibc_pattern_s     pat,
  input  wire logic                 window_end,
  output logic                      detected
);
  import ibc_pkg::*;

  logic [21:0] bit_cnt_reg;
  logic [21:0] miss_cnt_reg;
  logic        hit;

  // true when the newest len bits equal some rotation of the pattern
  function automatic logic rot_match(input logic [15:0] w, input logic [15:0] seq, input logic [4:0] len);
    logic any;
    logic ok;
    int   idx;
    any = 1'b0;
    for (int r = 0; r < 16; r++) begin
      ok = (r < int'(len));
      for (int k = 0; k < 16; k++) begin
        if (k < int'(len)) begin
          idx = k + r;
          if (idx >= int'(len)) begin
            idx = idx - int'(len);
          end
          if (w[int'(len) - 1 - k] != seq[15 - idx]) begin
            ok = 1'b0;
          end
        end
      end
      any = any | ok;
    end
    return any;
  endfunction : rot_match

  assign hit = rot_match(window, pat.seq, pat.len);

  // count bits and mismatching windows; a bit landing on window_end is dropped with the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg  <= '0;
      miss_cnt_reg <= '0;
    end else if (window_end) begin
      bit_cnt_reg  <= '0;
      miss_cnt_reg <= '0;
    end else if (bit_en) begin
      bit_cnt_reg  <= bit_cnt_reg + 22'h00_0001;
      miss_cnt_reg <= miss_cnt_reg + {21'h00_0000, ~hit};
    end
  end

  // one bit error spoils up to len windows, so a quarter of misses is tolerated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detected <= 1'b0;
    end else if (window_end) begin
      detected <= (bit_cnt_reg != 22'h00_0000) && ({miss_cnt_reg, 2'b00} <= {2'b00, bit_cnt_reg});
    end
  end

endmodule : ibc_code_det

/* verilog/ibc_loop_code_rx.sv */
// receive in-band loop code definitions, detectors and their AHB-Lite register slave
`timescale 1ns/1ns
module ibc_loop_code_rx #(
  parameter int INTEG_CYCLES = ibc_pkg::INTEG_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_data,
  output logic             up_code_detected,
  output logic             down_code_detected,
  output logic             irq
);
  import ibc_pkg::*;

  logic [7:0]   control_reg;
  logic [7:0]   up_low_reg;
  logic [7:0]   up_high_reg;
  logic [7:0]   down_low_reg;
  logic [7:0]   down_high_reg;
  logic [1:0]   status_reg;
  logic [1:0]   mask_reg;
  logic [15:0]  window_reg;
  logic [21:0]  timer_reg;
  logic         window_end_reg;
  logic         verdict_ready_reg;
  logic         wr_pend_reg;
  logic [7:0]   wr_idx_reg;
  logic         take;
  logic [7:0]   idx;
  logic [1:0]   status_set;
  logic [1:0]   status_clr;
  logic [31:0]  rd_word;
  ibc_pattern_s up_pat;
  ibc_pattern_s down_pat;

  // address phase is taken when selected, non-idle and the bus is ready
  assign take = hsel && htrans[1] && hready;
  assign idx  = (haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'b00) ? haddr[9:2] : 8'hff;

  // bus answers with zero wait states and always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // remember a write for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite;
      wr_idx_reg  <= idx;
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx == IDX_CONTROL) begin
      rd_word[7:0] = control_reg;
    end else if (idx == IDX_UP_LOW) begin
      rd_word[7:0] = up_low_reg;
    end else if (idx == IDX_UP_HIGH) begin
      rd_word[7:0] = up_high_reg;
    end else if (idx == IDX_DOWN_LOW) begin
      rd_word[7:0] = down_low_reg;
    end else if (idx == IDX_DOWN_HIGH) begin
      rd_word[7:0] = down_high_reg;
    end else if (idx == IDX_STATUS) begin
      rd_word[1:0] = status_reg;
    end else if (idx == IDX_MASK) begin
      rd_word[1:0] = mask_reg;
    end
  end

  // read data registered at the end of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // definition and control writes; each register only changes on its own index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg   <= RST_BYTE;
      up_low_reg    <= RST_BYTE;
      up_high_reg   <= RST_BYTE;
      down_low_reg  <= RST_BYTE;
      down_high_reg <= RST_BYTE;
      mask_reg      <= RST_FLAG;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == IDX_CONTROL) begin
        control_reg <= hwdata[7:0];
      end else if (wr_idx_reg == IDX_UP_LOW) begin
        up_low_reg <= hwdata[7:0];
      end else if (wr_idx_reg == IDX_UP_HIGH) begin
        up_high_reg <= hwdata[7:0];
      end else if (wr_idx_reg == IDX_DOWN_LOW) begin
        down_low_reg <= hwdata[7:0];
      end else if (wr_idx_reg == IDX_DOWN_HIGH) begin
        down_high_reg <= hwdata[7:0];
      end else if (wr_idx_reg == IDX_MASK) begin
        mask_reg <= hwdata[1:0];
      end
    end
  end

  // length decode: select 7 is the long setting, an 8-bit code is the same byte in both halves
  function automatic ibc_pattern_s make_pat(input logic [2:0] sel, input logic [7:0] lo, input logic [7:0] hi);
    ibc_pattern_s p;
    logic [7:0]   keep;
    p = '0;
    keep = 8'hff << (4'h7 - {1'b0, sel});
    if (sel == SEL_LONG) begin
      p.len = 5'h10;
      p.seq = {hi, lo};
    end else begin
      p.len = {2'b00, sel} + 5'h01;
      p.seq = {lo & keep, 8'h00};
    end
    return p;
  endfunction : make_pat

  assign up_pat   = make_pat(control_reg[UP_SEL_LSB +: 3], up_low_reg, up_high_reg);
  assign down_pat = make_pat(control_reg[DOWN_SEL_LSB +: 3], down_low_reg, down_high_reg);

  // newest received bit enters at bit 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      window_reg <= 16'h0000;
    end else if (rx_bit_en) begin
      window_reg <= {window_reg[14:0], rx_data};
    end
  end

  // integration timer, shared by both detectors so their verdicts line up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_reg      <= 22'h00_0000;
      window_end_reg <= 1'b0;
    end else if (timer_reg == 22'(INTEG_CYCLES - 1)) begin
      timer_reg      <= 22'h00_0000;
      window_end_reg <= 1'b1;
    end else begin
      timer_reg      <= timer_reg + 22'h00_0001;
      window_end_reg <= 1'b0;
    end
  end

  // verdicts settle one edge after window_end, so events wait for the fresh values, not last window's
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verdict_ready_reg <= 1'b0;
    end else begin
      verdict_ready_reg <= window_end_reg;
    end
  end

  ibc_code_det u_up_det (
    .clk        (hclk),
    .rst_n      (hresetn),
    .bit_en     (rx_bit_en),
    .window     (window_reg),
    .pat        (up_pat),
    .window_end (window_end_reg),
    .detected   (up_code_detected)
  );

  ibc_code_det u_down_det (
    .clk        (hclk),
    .rst_n      (hresetn),
    .bit_en     (rx_bit_en),
    .window     (window_reg),
    .pat        (down_pat),
    .window_end (window_end_reg),
    .detected   (down_code_detected)
  );

  // a verdict that stays set keeps raising its event every window; set beats a write-one clear
  assign status_set = {up_code_detected, down_code_detected} & {2{verdict_ready_reg}};
  assign status_clr = (wr_pend_reg && wr_idx_reg == IDX_STATUS) ? hwdata[1:0] : 2'b00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= RST_FLAG;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_up_low_write;
    wr_pend_reg && wr_idx_reg == IDX_UP_LOW |=> up_low_reg == $past(hwdata[7:0]);
  endproperty
  a_up_low_write: assert property (p_up_low_write) else $error("up low byte not written");

  property p_up_high_write;
    wr_pend_reg && wr_idx_reg == IDX_UP_HIGH |=> up_high_reg == $past(hwdata[7:0]);
  endproperty
  a_up_high_write: assert property (p_up_high_write) else $error("up high byte not written");

  property p_down_low_write;
    wr_pend_reg && wr_idx_reg == IDX_DOWN_LOW |=> down_low_reg == $past(hwdata[7:0]) && $stable(up_low_reg);
  endproperty
  a_down_low_write: assert property (p_down_low_write) else $error("down low write wrong or disturbed up");

  property p_up_mask;
    control_reg[UP_SEL_LSB +: 3] != SEL_LONG |-> up_pat.seq[7:0] == 8'h00 &&
      (up_pat.seq[15:8] & ~(8'hff << (4'h7 - {1'b0, control_reg[UP_SEL_LSB +: 3]}))) == 8'h00;
  endproperty
  a_up_mask: assert property (p_up_mask) else $error("up don't-care bits reach comparator");

  property p_down_len;
    control_reg[DOWN_SEL_LSB +: 3] != SEL_LONG |->
      down_pat.len == {2'b00, control_reg[DOWN_SEL_LSB +: 3]} + 5'h01 && down_pat.seq[7:0] == 8'h00;
  endproperty
  a_down_len: assert property (p_down_len) else $error("down length or mask wrong");

  property p_long_len;
    control_reg[UP_SEL_LSB +: 3] == SEL_LONG |-> up_pat.len == 5'h10 && up_pat.seq == {up_high_reg, up_low_reg};
  endproperty
  a_long_len: assert property (p_long_len) else $error("long up pattern wrong");

  property p_status_set;
    verdict_ready_reg && up_code_detected |=> status_reg[ST_UP] ##1
      irq == ($past(mask_reg[ST_UP]) || $past(status_reg[ST_DOWN] && mask_reg[ST_DOWN]));
  endproperty
  a_status_set: assert property (p_status_set) else $error("up status or irq missing");

  property p_window_period;
    window_end_reg |=> !window_end_reg;
  endproperty
  a_window_period: assert property (p_window_period) else $error("integration window too short");

  property p_readback;
    take && !hwrite && idx == IDX_DOWN_LOW |=> hrdata == {24'h00_0000, $past(down_low_reg)};
  endproperty
  a_readback: assert property (p_readback) else $error("down low readback wrong");

  c_up_seen:   cover property (window_end_reg && up_code_detected);
  c_down_seen: cover property (window_end_reg && down_code_detected);
  c_irq:       cover property ($rose(irq));
  c_clear:     cover property (status_reg[ST_UP] ##1 !status_reg[ST_UP]);

endmodule : ibc_loop_code_rx

/* verilog/ibc_pkg.sv */
// package for the receive in-band loop code block: register map, resets, timing, carrier types
package ibc_pkg;

  // word index of each register; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'h0a;
  localparam logic [7:0] IDX_UP_LOW    = 8'h0d;
  localparam logic [7:0] IDX_UP_HIGH   = 8'h0e;
  localparam logic [7:0] IDX_DOWN_LOW  = 8'h0f;
  localparam logic [7:0] IDX_DOWN_HIGH = 8'h10;
  localparam logic [7:0] IDX_STATUS    = 8'h11;
  localparam logic [7:0] IDX_MASK      = 8'h12;

  // field positions in the control register
  localparam int UP_SEL_LSB   = 3;
  localparam int DOWN_SEL_LSB = 0;
  localparam logic [2:0] SEL_LONG = 3'h7;   // 16 or 8 bit setting

  // status and mask bit positions
  localparam int ST_DOWN = 0;
  localparam int ST_UP   = 1;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_FLAG = 2'h0;

  // integration time
  localparam int CLK_KHZ      = 50_000;
  localparam int INTEG_MS     = 48;
  localparam int INTEG_CYCLES = INTEG_MS * CLK_KHZ;

  // a pattern as the comparator sees it: first bit at seq[15]
  typedef struct packed {
    logic [15:0] seq;
    logic [4:0]  len;
  } ibc_pattern_s;

endpackage : ibc_pkg
